//--- rwi_pkg.sv
// Shared constants and types for the reset and wake-up register block
package rwi_pkg;

  // ------------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_IRQ_FLAG   = 8'h01;
  localparam logic [7:0] ADDR_IRQ_PRIO   = 8'h02;
  localparam logic [7:0] ADDR_STATUS     = 8'h03;
  localparam logic [7:0] ADDR_MASK       = 8'h04;
  localparam logic [7:0] ADDR_PC_LOW     = 8'h05;
  localparam logic [7:0] ADDR_PC_HIGH    = 8'h06;
  localparam logic [7:0] ADDR_PC_UPPER   = 8'h07;
  localparam logic [7:0] ADDR_TOS_LOW    = 8'h08;
  localparam logic [7:0] ADDR_TOS_HIGH   = 8'h09;
  localparam logic [7:0] ADDR_TOS_UPPER  = 8'h0a;
  localparam logic [7:0] ADDR_STACK_PTR  = 8'h0b;
  localparam logic [7:0] ADDR_PORT_IN    = 8'h0c;
  localparam logic [7:0] ADDR_PORT_LATCH = 8'h0d;
  localparam logic [7:0] ADDR_PORT_DIR   = 8'h0e;
  localparam logic [7:0] ADDR_TMR_PERIOD = 8'h0f;
  localparam logic [7:0] ADDR_TMR_CTRL   = 8'h10;

  // ------------------------------------------------------------------
  // Field layouts and implemented-bit masks
  // ------------------------------------------------------------------
  localparam int         CTRL_LOW_GIE    = 0;
  localparam int         CTRL_HIGH_GIE   = 1;
  localparam int         CTRL_PINS_FREE  = 2;
  localparam logic [7:0] CTRL_USED       = 8'h07;
  localparam int         ST_WAKE         = 0;
  localparam int         ST_VECTOR       = 1;
  localparam int         ST_OVERFLOW     = 2;
  localparam logic [7:0] ST_USED         = 8'h07;
  localparam logic [7:0] TMR_CTRL_USED   = 8'h7f;
  localparam logic [7:0] PORT_FREE_MASK  = 8'hc0;

  // ------------------------------------------------------------------
  // Program counter, vectors and stack
  // ------------------------------------------------------------------
  localparam int          PC_W           = 21;
  localparam int          PC_HIGH_LSB    = 8;
  localparam int          PC_UPPER_LSB   = 16;
  localparam int          PC_UPPER_W     = 5;
  localparam logic [20:0] PC_RESET       = 21'h000000;
  localparam logic [20:0] VEC_HIGH       = 21'h000008;
  localparam logic [20:0] VEC_LOW        = 21'h000018;
  localparam int          PTR_W          = 5;
  localparam logic [4:0]  STACK_DEPTH    = 5'h1f;
  localparam logic [4:0]  PTR_RESET      = 5'h00;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] ZERO_RESET      = 8'h00;
  localparam logic [7:0] DIR_RESET       = 8'hff;
  localparam logic [7:0] LATCH_POR       = 8'h00;
  localparam logic [7:0] TMR_PERIOD_POR  = 8'hff;

  // Sequencer states
  typedef enum logic [2:0] {
    RWI_RUN    = 3'b001,
    RWI_SLEEP  = 3'b010,
    RWI_VECTOR = 3'b100
  } rwi_state_e;

endpackage

//--- rwi_port_gate.sv
// Oscillator-dependent gating of the upper two bits of port one
module rwi_port_gate (
  // Mode
  input  wire logic       pinsFree,
  // Stored and sampled values
  input  wire logic [7:0] pinIn,
  input  wire logic [7:0] latchIn,
  input  wire logic [7:0] dirIn,
  // Gated views
  output logic      [7:0] pinGated,
  output logic      [7:0] latchGated,
  output logic      [7:0] dirGated,
  output logic      [7:0] pinOut,
  output logic      [7:0] pinOe
);

  // Bits freed by the oscillator pass, others read zero
  function automatic logic [7:0] gateBits(input logic [7:0] v,
                                           input logic       free);
    gateBits = free ? v : (v & ~rwi_pkg::PORT_FREE_MASK);
  endfunction

  always_comb begin
    pinGated   = gateBits(pinIn, pinsFree);
    latchGated = gateBits(latchIn, pinsFree);
    dirGated   = gateBits(dirIn, pinsFree);
    pinOut     = latchGated;
    // Direction one means input; disabled bits are never driven
    pinOe      = gateBits(~dirIn, pinsFree);
  end

endmodule

//--- rwi_reset_wake.sv
// Reset, sleep and interrupt wake-up sequencer with its register bank
// What this block does
// - Interrupt wake-up from sleep always has a set flag causing it.
// - Wake with matching global enable loads pc with that priority vector.
// - Same wake pushes current pc to stack top and advances pointer, unless the pointer is at 31, which sets overflow instead.
// - Port one bits 6 and 7 work only when oscillator frees them.
// - Every unimplemented register bit reads zero.
module rwi_reset_wake (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // Register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  // Core side
  input  wire logic       resetOther,
  input  wire logic       sleepReq,
  input  wire logic       pcLoad,
  input  wire logic [20:0] pcNext,
  input  wire logic       retReq,
  input  wire logic [7:0] irqReq,
  output logic      [20:0] pcOut,
  output logic            sleeping,
  // Port one pins
  input  wire logic [7:0] pinIn,
  output logic      [7:0] pinOut,
  output logic      [7:0] pinOe,
  // Interrupt
  output logic            irqOut
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  rwi_pkg::rwi_state_e stateQ, stateD;
  logic [7:0]  ctrlQ, ctrlD, flagQ, flagD, prioQ, prioD;
  logic [7:0]  statusQ, statusD, maskQ, maskD;
  logic [7:0]  latchQ, latchD, dirQ, dirD, periodQ, periodD;
  logic [7:0]  tmrCtrlQ, tmrCtrlD, rdataD;
  logic [20:0] pcQ, pcD, tos;
  logic [4:0]  ptrQ, ptrD;
  logic        vecHighQ, vecHighD, pushEn;
  logic [20:0] stackMem [0:30];
  logic [7:0]  pinGated, latchGated, dirGated;
  logic        highPend, lowPend;

  // Write-one-to-clear with the hardware set winning
  function automatic logic [7:0] w1c(input logic [7:0] cur,
                                      input logic [7:0] set,
                                      input logic       clr,
                                      input logic [7:0] data);
    w1c = (cur & ~(clr ? data : 8'h00)) | set;
  endfunction

  function automatic logic wrHit(input logic       wr,
                                  input logic [7:0] a,
                                  input logic [7:0] target);
    wrHit = wr && (a == target);
  endfunction

  // ------------------------------------------------------------------
  // Port gating
  // ------------------------------------------------------------------
  rwi_port_gate u_gate (
    .pinsFree   (ctrlQ[rwi_pkg::CTRL_PINS_FREE]),
    .pinIn      (pinIn),
    .latchIn    (latchQ),
    .dirIn      (dirQ),
    .pinGated   (pinGated),
    .latchGated (latchGated),
    .dirGated   (dirGated),
    .pinOut     (pinOut),
    .pinOe      (pinOe)
  );

  // Stack top is the newest entry, zero when empty
  assign tos = (ptrQ == rwi_pkg::PTR_RESET) ? rwi_pkg::PC_RESET
                                             : stackMem[ptrQ - 5'h01];

  // Pending priorities seen against the global enables
  assign highPend = |(flagQ & prioQ) && ctrlQ[rwi_pkg::CTRL_HIGH_GIE];
  assign lowPend  = |(flagQ & ~prioQ) && ctrlQ[rwi_pkg::CTRL_LOW_GIE];

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    stateD   = stateQ;
    ctrlD    = ctrlQ;
    prioD    = prioQ;
    maskD    = maskQ;
    latchD   = latchQ;
    dirD     = dirQ;
    periodD  = periodQ;
    tmrCtrlD = tmrCtrlQ;
    pcD      = pcQ;
    ptrD     = ptrQ;
    vecHighD = vecHighQ;
    pushEn   = 1'b0;
    // Sources latch their flag whatever the state; the set beats a clear
    flagD    = w1c(flagQ, irqReq,
                   wrHit(regWr, regAddr, rwi_pkg::ADDR_IRQ_FLAG), regWdata);
    statusD  = w1c(statusQ, 8'h00,
                   wrHit(regWr, regAddr, rwi_pkg::ADDR_STATUS), regWdata);

    if (regWr) begin
      if (regAddr == rwi_pkg::ADDR_CTRL) begin
        ctrlD = regWdata & rwi_pkg::CTRL_USED;
      end else if (regAddr == rwi_pkg::ADDR_IRQ_PRIO) begin
        prioD = regWdata;
      end else if (regAddr == rwi_pkg::ADDR_MASK) begin
        maskD = regWdata & rwi_pkg::ST_USED;
      end else if (regAddr == rwi_pkg::ADDR_PORT_LATCH) begin
        latchD = regWdata;
      end else if (regAddr == rwi_pkg::ADDR_PORT_DIR) begin
        dirD = regWdata;
      end else if (regAddr == rwi_pkg::ADDR_TMR_PERIOD) begin
        periodD = regWdata;
      end else if (regAddr == rwi_pkg::ADDR_TMR_CTRL) begin
        tmrCtrlD = regWdata & rwi_pkg::TMR_CTRL_USED;
      end
    end

    case (stateQ)
      rwi_pkg::RWI_RUN: begin
        if (pcLoad) begin
          pcD = pcNext;
        end
        if (retReq && ptrQ != rwi_pkg::PTR_RESET) begin
          pcD  = tos;
          ptrD = ptrQ - 5'h01;
        end
        if (sleepReq) begin
          stateD = rwi_pkg::RWI_SLEEP;
        end
      end
      rwi_pkg::RWI_SLEEP: begin
        // only a set flag or resetOther ends sleep
        if (flagQ != 8'h00) begin
          statusD[rwi_pkg::ST_WAKE] = 1'b1;
          vecHighD = highPend;
          // vector only with a matching global enable
          if (highPend || lowPend) begin
            stateD = rwi_pkg::RWI_VECTOR;
          end else begin
            stateD = rwi_pkg::RWI_RUN;
          end
        end
      end
      rwi_pkg::RWI_VECTOR: begin
        if (ptrQ == rwi_pkg::STACK_DEPTH) begin
          statusD[rwi_pkg::ST_OVERFLOW] = 1'b1;
        end else begin
          pushEn = 1'b1;
          ptrD   = ptrQ + 5'h01;
        end
        pcD = vecHighQ ? rwi_pkg::VEC_HIGH : rwi_pkg::VEC_LOW;
        statusD[rwi_pkg::ST_VECTOR] = 1'b1;
        stateD = rwi_pkg::RWI_RUN;
      end
      default: stateD = rwi_pkg::RWI_RUN;
    endcase

    // warm resets reload most values, keep latch and period
    if (resetOther) begin
      stateD   = rwi_pkg::RWI_RUN;
      ctrlD    = rwi_pkg::ZERO_RESET;
      flagD    = rwi_pkg::ZERO_RESET;
      prioD    = rwi_pkg::ZERO_RESET;
      statusD  = rwi_pkg::ZERO_RESET;
      maskD    = rwi_pkg::ZERO_RESET;
      dirD     = rwi_pkg::DIR_RESET;
      tmrCtrlD = rwi_pkg::ZERO_RESET;
      pcD      = rwi_pkg::PC_RESET;
      ptrD     = rwi_pkg::PTR_RESET;
      vecHighD = 1'b0;
      pushEn   = 1'b0;
    end
  end

  // Read mux; data valid in the cycle after the strobe
  always_comb begin
    rdataD = 8'h00;
    if (regRd) begin
      if (regAddr == rwi_pkg::ADDR_CTRL) begin
        rdataD = ctrlQ;
      end else if (regAddr == rwi_pkg::ADDR_IRQ_FLAG) begin
        rdataD = flagQ;
      end else if (regAddr == rwi_pkg::ADDR_IRQ_PRIO) begin
        rdataD = prioQ;
      end else if (regAddr == rwi_pkg::ADDR_STATUS) begin
        rdataD = statusQ;
      end else if (regAddr == rwi_pkg::ADDR_MASK) begin
        rdataD = maskQ;
      end else if (regAddr == rwi_pkg::ADDR_PC_LOW) begin
        rdataD = pcQ[7:0];
      end else if (regAddr == rwi_pkg::ADDR_PC_HIGH) begin
        rdataD = pcQ[rwi_pkg::PC_HIGH_LSB +: 8];
      end else if (regAddr == rwi_pkg::ADDR_PC_UPPER) begin
        rdataD = {3'h0, pcQ[rwi_pkg::PC_UPPER_LSB +: rwi_pkg::PC_UPPER_W]};
      end else if (regAddr == rwi_pkg::ADDR_TOS_LOW) begin
        rdataD = tos[7:0];
      end else if (regAddr == rwi_pkg::ADDR_TOS_HIGH) begin
        rdataD = tos[rwi_pkg::PC_HIGH_LSB +: 8];
      end else if (regAddr == rwi_pkg::ADDR_TOS_UPPER) begin
        rdataD = {3'h0, tos[rwi_pkg::PC_UPPER_LSB +: rwi_pkg::PC_UPPER_W]};
      end else if (regAddr == rwi_pkg::ADDR_STACK_PTR) begin
        rdataD = {3'h0, ptrQ};
      end else if (regAddr == rwi_pkg::ADDR_PORT_IN) begin
        rdataD = pinGated;
      end else if (regAddr == rwi_pkg::ADDR_PORT_LATCH) begin
        rdataD = latchGated;
      end else if (regAddr == rwi_pkg::ADDR_PORT_DIR) begin
        rdataD = dirGated;
      end else if (regAddr == rwi_pkg::ADDR_TMR_PERIOD) begin
        rdataD = periodQ;
      end else if (regAddr == rwi_pkg::ADDR_TMR_CTRL) begin
        rdataD = tmrCtrlQ;
      end
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // power-on and brown-out load initial values
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stateQ   <= rwi_pkg::RWI_RUN;
      ctrlQ    <= rwi_pkg::ZERO_RESET;
      flagQ    <= rwi_pkg::ZERO_RESET;
      prioQ    <= rwi_pkg::ZERO_RESET;
      statusQ  <= rwi_pkg::ZERO_RESET;
      maskQ    <= rwi_pkg::ZERO_RESET;
      latchQ   <= rwi_pkg::LATCH_POR;
      dirQ     <= rwi_pkg::DIR_RESET;
      periodQ  <= rwi_pkg::TMR_PERIOD_POR;
      tmrCtrlQ <= rwi_pkg::ZERO_RESET;
      pcQ      <= rwi_pkg::PC_RESET;
      ptrQ     <= rwi_pkg::PTR_RESET;
      vecHighQ <= 1'b0;
      regRdata <= rwi_pkg::ZERO_RESET;
    end else begin
      stateQ   <= stateD;
      ctrlQ    <= ctrlD;
      flagQ    <= flagD;
      prioQ    <= prioD;
      statusQ  <= statusD;
      maskQ    <= maskD;
      latchQ   <= latchD;
      dirQ     <= dirD;
      periodQ  <= periodD;
      tmrCtrlQ <= tmrCtrlD;
      pcQ      <= pcD;
      ptrQ     <= ptrD;
      vecHighQ <= vecHighD;
      regRdata <= rdataD;
    end
  end

  // Stack storage has no reset; the pointer alone says what is valid
  always_ff @(posedge clk_sys) begin
    if (pushEn) begin
      stackMem[ptrQ] <= pcQ;
    end
  end

  assign pcOut    = pcQ;
  assign sleeping = (stateQ == rwi_pkg::RWI_SLEEP);
  assign irqOut   = |(statusQ & maskQ);

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  flag_set_wins_a: assert property (
    (irqReq != 8'h00 && !resetOther) |=> ((flagQ & $past(irqReq)) == $past(irqReq)))
    else $error("Interrupt flag lost against a clear");

  wake_has_flag_a: assert property (
    (stateQ == rwi_pkg::RWI_SLEEP && !resetOther)
      ##1 (stateQ != rwi_pkg::RWI_SLEEP) |-> ($past(flagQ) != 8'h00))
    else $error("Left sleep without a flag set");

  vector_load_a: assert property (
    (stateQ == rwi_pkg::RWI_VECTOR && !resetOther)
      |=> (pcQ == ($past(vecHighQ) ? rwi_pkg::VEC_HIGH : rwi_pkg::VEC_LOW)))
    else $error("Wrong interrupt vector loaded");

  stack_push_a: assert property (
    (stateQ == rwi_pkg::RWI_VECTOR && !resetOther
      && ptrQ != rwi_pkg::STACK_DEPTH)
      |=> (ptrQ == $past(ptrQ) + 5'h01) && (tos == $past(pcQ)))
    else $error("Stack top or pointer not updated on wake");

  port_gate_a: assert property (
    (regRd && regAddr >= rwi_pkg::ADDR_PORT_IN
      && regAddr <= rwi_pkg::ADDR_PORT_DIR
      && !ctrlQ[rwi_pkg::CTRL_PINS_FREE])
      |=> ((regRdata & rwi_pkg::PORT_FREE_MASK) == 8'h00))
    else $error("Disabled port bits read nonzero");

  unimpl_zero_a: assert property (
    (regRd && (regAddr == rwi_pkg::ADDR_TMR_CTRL
      || regAddr == rwi_pkg::ADDR_STACK_PTR))
      |=> (regRdata[7] == 1'b0))
    else $error("Unimplemented bit read nonzero");

  wake_keeps_a: assert property (
    (stateQ == rwi_pkg::RWI_SLEEP && !regWr)
      |=> (latchQ == $past(latchQ)) && (periodQ == $past(periodQ))
          && (dirQ == $past(dirQ) || $past(resetOther)))
    else $error("Sleep or wake changed register contents");

endmodule

//--- tb_reset_wakeup_register_init.sv
// Self-checking testbench for the reset and wake-up register block
module tb_reset_wakeup_register_init;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------------
  // Signals and design instance
  // ------------------------------------------------------------------
  logic        clk_sys;
  logic        rst_b;
  logic [7:0]  regAddr;
  logic [7:0]  regWdata;
  logic        regWr;
  logic        regRd;
  logic [7:0]  regRdata;
  logic        resetOther;
  logic        sleepReq;
  logic        pcLoad;
  logic [20:0] pcNext;
  logic        retReq;
  logic [7:0]  irqReq;
  logic [20:0] pcOut;
  logic        sleeping;
  logic [7:0]  pinIn;
  logic [7:0]  pinOut;
  logic [7:0]  pinOe;
  logic        irqOut;
  int          failures;
  int          totalChecks;
  logic [7:0]  lowSix;

  rwi_reset_wake u_rwi_reset_wake (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .regAddr    (regAddr),
    .regWdata   (regWdata),
    .regWr      (regWr),
    .regRd      (regRd),
    .regRdata   (regRdata),
    .resetOther (resetOther),
    .sleepReq   (sleepReq),
    .pcLoad     (pcLoad),
    .pcNext     (pcNext),
    .retReq     (retReq),
    .irqReq     (irqReq),
    .pcOut      (pcOut),
    .sleeping   (sleeping),
    .pinIn      (pinIn),
    .pinOut     (pinOut),
    .pinOe      (pinOe),
    .irqOut     (irqOut)
  );

  // 40 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  // Compare and count; four-state so an unknown never matches
  task automatic chk(input string nm, input logic [20:0] seen,
                     input logic [20:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [7:0] exp);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd   <= 1'b0;
    #1 chk(nm, regRdata, exp);
  endtask

  // Clear old events, sleep, wake on the given source
  task automatic do_wake(input logic [7:0] src);
    int n;
    n = 0;
    wr(rwi_pkg::ADDR_IRQ_FLAG, 8'hff);
    wr(rwi_pkg::ADDR_STATUS, 8'h07);
    @(posedge clk_sys);
    sleepReq <= 1'b1;
    @(posedge clk_sys);
    sleepReq <= 1'b0;
    #1 chk("sleeping", sleeping, 1'b1);
    @(posedge clk_sys);
    irqReq <= src;
    @(posedge clk_sys);
    irqReq <= 8'h00;
    #1;
    while (sleeping === 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1 n++;
    end
    repeat (3) @(posedge clk_sys);
    #1 chk("woken", sleeping, 1'b0);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // power-on values
  task automatic t_por();
    logic [7:0] ad[12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
                           8'h07, 8'h0b, 8'h0d, 8'h0e, 8'h0f, 8'h10};
    logic [7:0] ev[12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                           8'h00, 8'h00, 8'h00, 8'h3f, 8'hff, 8'h00};
    for (int i = 0; i < 12; i++) begin
      rdc("por reg", ad[i], ev[i]);
    end
    chk("por pinOe", pinOe, 8'h00);
    chk("por irqOut", irqOut, 1'b0);
    chk("por pc", pcOut, rwi_pkg::PC_RESET);
  endtask

  task automatic t_unimpl();
    wr(rwi_pkg::ADDR_CTRL, 8'hf8);
    rdc("ctrl unused", rwi_pkg::ADDR_CTRL, 8'h00);
    wr(rwi_pkg::ADDR_TMR_CTRL, 8'hff);
    rdc("tmr ctrl", rwi_pkg::ADDR_TMR_CTRL, rwi_pkg::TMR_CTRL_USED);
    wr(8'h3c, 8'hff);
    rdc("unmapped", 8'h3c, 8'h00);
  endtask

  // upper port bits follow the oscillator mode
  task automatic t_port();
    wr(rwi_pkg::ADDR_PORT_LATCH, 8'hff);
    wr(rwi_pkg::ADDR_PORT_DIR, 8'hc0);
    @(posedge clk_sys);
    pinIn <= 8'hff;
    rdc("pin gated", rwi_pkg::ADDR_PORT_IN, lowSix);
    rdc("latch gated", rwi_pkg::ADDR_PORT_LATCH, lowSix);
    rdc("dir gated", rwi_pkg::ADDR_PORT_DIR, 8'h00);
    chk("pinOut gated", pinOut, lowSix);
    chk("pinOe gated", pinOe, lowSix);
    wr(rwi_pkg::ADDR_CTRL, 8'h04);
    rdc("pin free", rwi_pkg::ADDR_PORT_IN, 8'hff);
    rdc("dir free", rwi_pkg::ADDR_PORT_DIR, 8'hc0);
    chk("pinOut free", pinOut, 8'hff);
    chk("pinOe free", pinOe, lowSix);
    wr(rwi_pkg::ADDR_PORT_DIR, 8'h00);
    @(posedge clk_sys);
    #1 chk("pinOe all", pinOe, 8'hff);
    wr(rwi_pkg::ADDR_CTRL, 8'h00);
  endtask

  // high-priority wake with push and vector
  task automatic t_wake_high();
    @(posedge clk_sys);
    pcLoad <= 1'b1;
    pcNext <= 21'h012345;
    @(posedge clk_sys);
    pcLoad <= 1'b0;
    wr(rwi_pkg::ADDR_CTRL, 8'h02);
    wr(rwi_pkg::ADDR_IRQ_PRIO, 8'h01);
    wr(rwi_pkg::ADDR_MASK, 8'h01);
    do_wake(8'h01);
    rdc("flag hi", rwi_pkg::ADDR_IRQ_FLAG, 8'h01);
    chk("vec hi", pcOut, rwi_pkg::VEC_HIGH);
    rdc("tos lo", rwi_pkg::ADDR_TOS_LOW, 8'h45);
    rdc("tos hi", rwi_pkg::ADDR_TOS_HIGH, 8'h23);
    rdc("tos up", rwi_pkg::ADDR_TOS_UPPER, 8'h01);
    rdc("ptr one", rwi_pkg::ADDR_STACK_PTR, 8'h01);
    rdc("status hi", rwi_pkg::ADDR_STATUS, 8'h03);
    chk("irq on", irqOut, 1'b1);
    wr(rwi_pkg::ADDR_MASK, 8'h00);
    @(posedge clk_sys);
    #1 chk("irq masked", irqOut, 1'b0);
    wr(rwi_pkg::ADDR_MASK, 8'h01);
    wr(rwi_pkg::ADDR_STATUS, 8'h07);
    @(posedge clk_sys);
    #1 chk("irq cleared", irqOut, 1'b0);
  endtask

  // low-priority wake, then a wake with no enable
  task automatic t_wake_low();
    wr(rwi_pkg::ADDR_CTRL, 8'h01);
    wr(rwi_pkg::ADDR_IRQ_PRIO, 8'h00);
    do_wake(8'h02);
    rdc("flag lo", rwi_pkg::ADDR_IRQ_FLAG, 8'h02);
    chk("vec lo", pcOut, rwi_pkg::VEC_LOW);
    rdc("tos lo2", rwi_pkg::ADDR_TOS_LOW, 8'h08);
    rdc("tos up2", rwi_pkg::ADDR_TOS_UPPER, 8'h00);
    rdc("ptr two", rwi_pkg::ADDR_STACK_PTR, 8'h02);
    wr(rwi_pkg::ADDR_CTRL, 8'h00);
    do_wake(8'h04);
    rdc("flag none", rwi_pkg::ADDR_IRQ_FLAG, 8'h04);
    chk("pc kept", pcOut, rwi_pkg::VEC_LOW);
    rdc("ptr kept", rwi_pkg::ADDR_STACK_PTR, 8'h02);
    rdc("status none", rwi_pkg::ADDR_STATUS, 8'h01);
  endtask

  // pops give back the pushed pc; an empty stack ignores a pop
  task automatic t_return();
    // Pop and load in one cycle: the pop must win
    @(posedge clk_sys);
    retReq <= 1'b1;
    pcLoad <= 1'b1;
    pcNext <= 21'h000abc;
    @(posedge clk_sys);
    retReq <= 1'b0;
    pcLoad <= 1'b0;
    #1 chk("pop first", pcOut, rwi_pkg::VEC_HIGH);
    rdc("ptr popped", rwi_pkg::ADDR_STACK_PTR, 8'h01);
    @(posedge clk_sys);
    retReq <= 1'b1;
    @(posedge clk_sys);
    retReq <= 1'b0;
    #1 chk("pop second", pcOut, 21'h012345);
    @(posedge clk_sys);
    retReq <= 1'b1;
    @(posedge clk_sys);
    retReq <= 1'b0;
    #1 chk("pop empty", pcOut, 21'h012345);
    rdc("ptr empty", rwi_pkg::ADDR_STACK_PTR, 8'h00);
  endtask

  // warm reset reloads most, keeps latch and period
  task automatic t_warm();
    wr(rwi_pkg::ADDR_CTRL, 8'h03);
    wr(rwi_pkg::ADDR_TMR_PERIOD, 8'h5a);
    @(posedge clk_sys);
    resetOther <= 1'b1;
    @(posedge clk_sys);
    resetOther <= 1'b0;
    rdc("warm ctrl", rwi_pkg::ADDR_CTRL, 8'h00);
    rdc("warm dir", rwi_pkg::ADDR_PORT_DIR, lowSix);
    rdc("warm latch", rwi_pkg::ADDR_PORT_LATCH, lowSix);
    rdc("warm period", rwi_pkg::ADDR_TMR_PERIOD, 8'h5a);
    rdc("warm ptr", rwi_pkg::ADDR_STACK_PTR, 8'h00);
    chk("warm pc", pcOut, rwi_pkg::PC_RESET);
    // A power-on reset in mid-run must reload what a warm reset kept
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdc("por period", rwi_pkg::ADDR_TMR_PERIOD,
        rwi_pkg::TMR_PERIOD_POR);
    rdc("por latch", rwi_pkg::ADDR_PORT_LATCH, rwi_pkg::LATCH_POR);
  endtask

  // ------------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles; this limit is generous
  initial begin
    #(25 * 5000);
    failures++;
    end_sim();
  end

  // Inputs idle at time zero, reset for 12 cycles
  initial begin
    lowSix       = ~rwi_pkg::PORT_FREE_MASK;
    failures     = 0;
    totalChecks  = 0;
    rst_b        = 1'b0;
    regAddr      = 8'h00;
    regWdata     = 8'h00;
    regWr        = 1'b0;
    regRd        = 1'b0;
    resetOther   = 1'b0;
    sleepReq     = 1'b0;
    pcLoad       = 1'b0;
    pcNext       = 21'h000000;
    retReq       = 1'b0;
    irqReq       = 8'h00;
    pinIn        = 8'h00;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_por();
    t_unimpl();
    t_port();
    t_wake_high();
    t_wake_low();
    t_return();
    t_warm();
    end_sim();
  end
endmodule
